// [core/pau_core.sv]
// Process alarm unit: alarm evaluation, blocking, timers and AHB-Lite registers
//
// Overview of operation
// - Four alarm channels, evaluated independently, each one of nine functions.
// - An alarm set to off never drives its output.
// - Input fault alarm follows sensor broken, out of range or shorted.
// - Program event alarm active only in the chosen running program segments.
// - Heater fault alarm follows the external current-sensing fault signal.
// - Absolute minimum triggers when value is strictly below threshold.
// - Absolute maximum triggers when value is strictly above threshold.
// - Positive band threshold: trigger when value lies outside setpoint plus/minus threshold.
// - Negative band threshold: trigger when value lies inside that band.
// - Deviation under triggers below setpoint minus threshold.
// - Deviation over triggers above setpoint plus threshold.
// - Maximum, band and over alarms also trigger on any sensor fault.
// - Both timers zero: output follows the recognised condition.
// - First timer only: output on for first time once, then off.
// - Second timer only: output on after second time, while condition persists.
// - Both timers: output alternates on first time, off second time.
// - Indicator follows recognised condition, not the timed output.
// - Initial blocking ignores a condition at power-up or run stop until cleared.
// - Initial blocking never applies to input fault alarms.
// - Run input open forces alarm outputs off.
//
// Chosen here: the address map and register access over AHB-Lite.
`default_nettype none
module pau_core #(
  parameter int SEC_CYCLES = pau_pkg::SEC_CYCLES
) (
  input  wire logic                                   hclk,
  input  wire logic                                   hresetn,
  input  wire logic                                   hsel,
  input  wire logic [31:0]                            haddr,
  input  wire logic [1:0]                             htrans,
  input  wire logic                                   hwrite,
  input  wire logic [2:0]                             hsize,
  input  wire logic [31:0]                            hwdata,
  input  wire logic                                   hready,
  output logic [31:0]                                 hrdata,
  output logic                                        hreadyout,
  output logic                                        hresp,
  input  wire logic signed [pau_pkg::VAL_W-1:0]       pv_value,
  input  wire logic                                   pv_update,
  input  wire logic                                   sensor_fault,
  input  wire logic                                   prog_running,
  input  wire logic [3:0]                             prog_segment,
  input  wire logic                                   heater_fault_pin,
  input  wire logic                                   run_pin,
  output logic [pau_pkg::NUM_ALARMS-1:0]              alarm_out,
  output logic [pau_pkg::NUM_ALARMS-1:0]              alarm_led
);
  localparam int NA = pau_pkg::NUM_ALARMS;
  localparam int SW = $clog2(SEC_CYCLES + 1);
  localparam logic [SW-1:0] SEC_LAST = SW'(SEC_CYCLES - 1);

  pau_pkg::pau_cfg_t                 cfg_ff [NA];
  logic signed [pau_pkg::VAL_W-1:0]  sp_ff;
  pau_pkg::pau_req_t                 req_ff;
  logic                              rd_pend_ff;
  logic [31:0]                       hrdata_ff;
  logic                              hreadyout_ff;
  logic                              hresp_ff;
  logic [31:0]                       rdata_w;
  logic                              run_m_ff, run_s_ff, run_d_ff;
  logic                              heat_m_ff, heat_s_ff;
  logic [SW-1:0]                     sec_cnt_ff;
  logic                              sec_tick_ff;
  logic [NA-1:0]                     raw_ff;
  logic [NA-1:0]                     blk_ff;
  logic                              eval_d_ff;
  logic [NA-1:0]                     rec_w;
  pau_pkg::pau_tst_t                 st_ff  [NA];
  logic [pau_pkg::CNT_W-1:0]         cnt_ff [NA];
  logic [NA-1:0]                     out_ff;
  logic [NA-1:0]                     led_ff;
  logic                              take_w;

  // Alarm condition of one channel for the current measurement
  function automatic logic pau_eval(input pau_pkg::pau_cfg_t c,
                                    input logic signed [15:0] pv,
                                    input logic signed [15:0] sp,
                                    input logic sflt,
                                    input logic hflt,
                                    input logic prun,
                                    input logic [3:0] seg);
    logic signed [16:0] pv17;
    logic signed [16:0] thr17;
    logic signed [16:0] hi17;
    logic signed [16:0] lo17;
    logic               res;
    pv17  = {pv[15], pv};
    thr17 = {c.thresh[15], c.thresh};
    hi17  = 17'({sp[15], sp} + thr17);
    lo17  = 17'({sp[15], sp} - thr17);
    res   = 1'b0;
    case (c.func)
      pau_pkg::AF_OFF:       res = 1'b0;
      pau_pkg::AF_IN_FAULT:  res = sflt;
      pau_pkg::AF_PROG_EVT:  res = prun && (seg != 4'h0) && (seg <= 4'h9)
                                   && c.segs[4'(seg - 4'h1)];
      pau_pkg::AF_HEAT_FLT:  res = hflt;
      pau_pkg::AF_ABS_MIN:   res = pv < c.thresh;
      pau_pkg::AF_ABS_MAX:   res = sflt || (pv > c.thresh);
      pau_pkg::AF_DEV_BAND: begin
        if (c.thresh[15]) begin
          res = sflt || (pv17 >= hi17 && pv17 <= lo17);
        end else begin
          res = sflt || pv17 < lo17 || pv17 > hi17;
        end
      end
      pau_pkg::AF_DEV_UNDER: res = pv17 < lo17;
      pau_pkg::AF_DEV_OVER:  res = sflt || (pv17 > hi17);
      default:               res = 1'b0;
    endcase
    return res;
  endfunction : pau_eval

  // Address offset of channel n in a register group
  function automatic logic [7:0] pau_ofs(input logic [7:0] base, input int n);
    return 8'(base + 8'(n) * pau_pkg::OFS_STRIDE);
  endfunction : pau_ofs

  // Bus slave: reads take one wait state so a preceding write is always seen
  assign take_w = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff       <= '0;
      rd_pend_ff   <= 1'b0;
      hrdata_ff    <= pau_pkg::RST_WORD;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
      if (take_w) begin
        req_ff.addr  <= haddr[pau_pkg::ADDR_W-1:0];
        req_ff.write <= hwrite;
        req_ff.read  <= !hwrite;
      end else if (hready) begin
        req_ff <= '0;
      end
      rd_pend_ff <= take_w && !hwrite;
      if (take_w && !hwrite) begin
        hreadyout_ff <= 1'b0;
      end else if (rd_pend_ff) begin
        hreadyout_ff <= 1'b1;
        hrdata_ff    <= rdata_w;
      end
    end
  end

  always_comb begin
    rdata_w = pau_pkg::RST_WORD;
    if (req_ff.addr == pau_pkg::OFS_FUNC) begin
      for (int i = 0; i < NA; i++) begin
        rdata_w[i*pau_pkg::FUNC_FLD_W +: pau_pkg::FUNC_FLD_W] = cfg_ff[i].func;
      end
    end else if (req_ff.addr == pau_pkg::OFS_BLOCK) begin
      for (int i = 0; i < NA; i++) begin
        rdata_w[i] = cfg_ff[i].block_en;
      end
    end else if (req_ff.addr == pau_pkg::OFS_SETPOINT) begin
      rdata_w[pau_pkg::VAL_W-1:0] = sp_ff;
    end else if (req_ff.addr == pau_pkg::OFS_STATUS) begin
      rdata_w[pau_pkg::STAT_LED_LSB +: NA] = led_ff;
      rdata_w[pau_pkg::STAT_OUT_LSB +: NA] = out_ff;
      rdata_w[pau_pkg::STAT_RUN_BIT]       = run_s_ff;
      rdata_w[pau_pkg::STAT_BLK_LSB +: NA] = blk_ff;
    end else begin
      for (int i = 0; i < NA; i++) begin
        if (req_ff.addr == pau_ofs(pau_pkg::OFS_THR_BASE, i)) begin
          rdata_w[pau_pkg::VAL_W-1:0] = cfg_ff[i].thresh;
        end
        if (req_ff.addr == pau_ofs(pau_pkg::OFS_TIM_BASE, i)) begin
          rdata_w[pau_pkg::TIM_T1_LSB +: pau_pkg::CNT_W] = cfg_ff[i].t1;
          rdata_w[pau_pkg::TIM_T2_LSB +: pau_pkg::CNT_W] = cfg_ff[i].t2;
        end
        if (req_ff.addr == pau_ofs(pau_pkg::OFS_SEG_BASE, i)) begin
          rdata_w[pau_pkg::SEG_W-1:0] = cfg_ff[i].segs;
        end
      end
    end
  end

  // Register writes land in the data phase; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_ff <= pau_pkg::RST_VAL;
      for (int i = 0; i < NA; i++) begin
        cfg_ff[i] <= '{func: pau_pkg::AF_OFF, thresh: pau_pkg::RST_VAL,
                       t1: pau_pkg::RST_CNT, t2: pau_pkg::RST_CNT,
                       segs: pau_pkg::RST_SEGS, block_en: 1'b0};
      end
    end else if (req_ff.write) begin
      if (req_ff.addr == pau_pkg::OFS_SETPOINT) begin
        sp_ff <= hwdata[pau_pkg::VAL_W-1:0];
      end
      for (int i = 0; i < NA; i++) begin
        if (req_ff.addr == pau_pkg::OFS_FUNC) begin
          cfg_ff[i].func <= pau_pkg::pau_func_t'(
            hwdata[i*pau_pkg::FUNC_FLD_W +: pau_pkg::FUNC_FLD_W]);
        end
        if (req_ff.addr == pau_pkg::OFS_BLOCK) begin
          cfg_ff[i].block_en <= hwdata[i];
        end
        if (req_ff.addr == pau_ofs(pau_pkg::OFS_THR_BASE, i)) begin
          cfg_ff[i].thresh <= hwdata[pau_pkg::VAL_W-1:0];
        end
        if (req_ff.addr == pau_ofs(pau_pkg::OFS_TIM_BASE, i)) begin
          cfg_ff[i].t1 <= hwdata[pau_pkg::TIM_T1_LSB +: pau_pkg::CNT_W];
          cfg_ff[i].t2 <= hwdata[pau_pkg::TIM_T2_LSB +: pau_pkg::CNT_W];
        end
        if (req_ff.addr == pau_ofs(pau_pkg::OFS_SEG_BASE, i)) begin
          cfg_ff[i].segs <= hwdata[pau_pkg::SEG_W-1:0];
        end
      end
    end
  end

  // Pin synchronisers; run_d_ff only feeds the stop edge detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_m_ff  <= 1'b0;
      run_s_ff  <= 1'b0;
      run_d_ff  <= 1'b0;
      heat_m_ff <= 1'b0;
      heat_s_ff <= 1'b0;
    end else begin
      run_m_ff  <= run_pin;
      run_s_ff  <= run_m_ff;
      run_d_ff  <= run_s_ff;
      heat_m_ff <= heater_fault_pin;
      heat_s_ff <= heat_m_ff;
    end
  end

  // Free-running seconds; timer phase is not tied to the event, so a time can run up to 1 s short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt_ff  <= '0;
      sec_tick_ff <= 1'b0;
    end else begin
      sec_tick_ff <= (sec_cnt_ff == SEC_LAST);
      sec_cnt_ff  <= (sec_cnt_ff == SEC_LAST) ? '0 : SW'(sec_cnt_ff + 1'b1);
    end
  end

  // Condition evaluation and initial blocking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_ff    <= '0;
      blk_ff    <= '1;
      eval_d_ff <= 1'b0;
    end else begin
      eval_d_ff <= pv_update;
      for (int i = 0; i < NA; i++) begin
        if (pv_update) begin
          raw_ff[i] <= pau_eval(cfg_ff[i], pv_value, sp_ff, sensor_fault,
                                heat_s_ff, prog_running, prog_segment);
        end
        // Re-arming on a stop wins over a clear in the same cycle
        if (run_d_ff && !run_s_ff) begin
          blk_ff[i] <= 1'b1;
        // Stale or off results must not count as a non-alarm, else power-up arming is lost
        end else if (eval_d_ff && !raw_ff[i] && cfg_ff[i].func != pau_pkg::AF_OFF) begin
          blk_ff[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NA; i++) begin
      rec_w[i] = raw_ff[i] && !(blk_ff[i] && cfg_ff[i].block_en
                 && cfg_ff[i].func != pau_pkg::AF_IN_FAULT);
    end
  end

  // Output timers, one per channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NA; i++) begin
        st_ff[i]  <= pau_pkg::TS_IDLE;
        cnt_ff[i] <= pau_pkg::RST_CNT;
      end
    end else begin
      for (int i = 0; i < NA; i++) begin
        if (!rec_w[i]) begin
          st_ff[i]  <= pau_pkg::TS_IDLE;
          cnt_ff[i] <= pau_pkg::RST_CNT;
        end else begin
          case (st_ff[i])
            pau_pkg::TS_IDLE: begin
              if (cfg_ff[i].t1 == pau_pkg::RST_CNT && cfg_ff[i].t2 != pau_pkg::RST_CNT) begin
                st_ff[i]  <= pau_pkg::TS_OFF;
                cnt_ff[i] <= cfg_ff[i].t2;
              end else begin
                st_ff[i]  <= pau_pkg::TS_ON;
                cnt_ff[i] <= cfg_ff[i].t1;
              end
            end
            pau_pkg::TS_ON: begin
              if (cnt_ff[i] != pau_pkg::RST_CNT && sec_tick_ff) begin
                if (cnt_ff[i] == pau_pkg::CNT_ONE) begin
                  st_ff[i]  <= pau_pkg::TS_OFF;
                  cnt_ff[i] <= cfg_ff[i].t2;
                end else begin
                  cnt_ff[i] <= cnt_ff[i] - pau_pkg::CNT_ONE;
                end
              end
            end
            pau_pkg::TS_OFF: begin
              if (cnt_ff[i] != pau_pkg::RST_CNT && sec_tick_ff) begin
                if (cnt_ff[i] == pau_pkg::CNT_ONE) begin
                  st_ff[i]  <= pau_pkg::TS_ON;
                  cnt_ff[i] <= cfg_ff[i].t1;
                end else begin
                  cnt_ff[i] <= cnt_ff[i] - pau_pkg::CNT_ONE;
                end
              end
            end
            default: begin
              st_ff[i]  <= pau_pkg::TS_IDLE;
              cnt_ff[i] <= pau_pkg::RST_CNT;
            end
          endcase
        end
      end
    end
  end

  // Outputs and indicators
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ff <= '0;
      led_ff <= '0;
    end else begin
      for (int i = 0; i < NA; i++) begin
        out_ff[i] <= run_s_ff && st_ff[i] == pau_pkg::TS_ON
                     && cfg_ff[i].func != pau_pkg::AF_OFF;
        led_ff[i] <= rec_w[i];
      end
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;
  assign alarm_out = out_ff;
  assign alarm_led = led_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  off_never_a: assert property (
    cfg_ff[0].func == pau_pkg::AF_OFF && $past(cfg_ff[0].func) == pau_pkg::AF_OFF
    |-> !out_ff[0]) else $error("Alarm output on while function is off");
  run_off_a: assert property (
    !run_s_ff |=> out_ff == '0) else $error("Alarm output on while stopped");
  abs_min_a: assert property (
    pv_update && cfg_ff[0].func == pau_pkg::AF_ABS_MIN && pv_value < cfg_ff[0].thresh
    |=> raw_ff[0]) else $error("Minimum alarm missed");
  sens_max_a: assert property (
    pv_update && cfg_ff[0].func == pau_pkg::AF_ABS_MAX && sensor_fault
    |=> raw_ff[0]) else $error("Sensor fault did not raise maximum alarm");
  no_block_a: assert property (
    cfg_ff[0].func == pau_pkg::AF_IN_FAULT && raw_ff[0] |-> rec_w[0] ##1 led_ff[0])
    else $error("Input fault alarm was blocked");
  blocked_a: assert property (
    blk_ff[0] && cfg_ff[0].block_en && cfg_ff[0].func == pau_pkg::AF_ABS_MIN
    |=> !led_ff[0]) else $error("Blocked alarm shown");
  follow_a: assert property (
    st_ff[0] == pau_pkg::TS_IDLE && rec_w[0] && cfg_ff[0].t1 == pau_pkg::RST_CNT
    && cfg_ff[0].t2 == pau_pkg::RST_CNT && run_s_ff ##1 rec_w[0] && run_s_ff
    |=> out_ff[0]) else $error("Untimed output did not follow alarm");
  delay_a: assert property (
    st_ff[0] == pau_pkg::TS_IDLE && rec_w[0] && cfg_ff[0].t1 == pau_pkg::RST_CNT
    && cfg_ff[0].t2 != pau_pkg::RST_CNT
    |=> st_ff[0] == pau_pkg::TS_OFF && cnt_ff[0] == $past(cfg_ff[0].t2))
    else $error("Delay did not start");
  pulse_end_a: assert property (
    st_ff[0] == pau_pkg::TS_ON && cnt_ff[0] == pau_pkg::CNT_ONE && sec_tick_ff
    && rec_w[0] && cfg_ff[0].t2 == pau_pkg::RST_CNT
    |=> st_ff[0] == pau_pkg::TS_OFF ##1 !out_ff[0]) else $error("Pulse did not end");
  rd_wait_a: assert property (
    take_w && !hwrite |=> !hreadyout_ff ##1 hreadyout_ff) else $error("Read latency wrong");

  pulse_c: cover property (st_ff[0] == pau_pkg::TS_ON ##1 st_ff[0] == pau_pkg::TS_OFF);
  delay_c: cover property (st_ff[0] == pau_pkg::TS_OFF ##1 st_ff[0] == pau_pkg::TS_ON);
  unblock_c: cover property (blk_ff[0] ##1 !blk_ff[0] ##[1:20] led_ff[0]);
endmodule : pau_core
`default_nettype wire

// [core/pau_pkg.sv]
// Constants, types and register map of the process alarm unit
`default_nettype none
package pau_pkg;
  localparam int NUM_ALARMS = 4;
  localparam int VAL_W      = 16;
  localparam int CNT_W      = 16;
  localparam int SEG_W      = 9;
  localparam int ADDR_W     = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FUNC     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BLOCK    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SETPOINT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_THR_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TIM_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_SEG_BASE = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_STRIDE   = 8'h04;

  // Field positions
  localparam int FUNC_FLD_W   = 4;
  localparam int TIM_T1_LSB   = 0;
  localparam int TIM_T2_LSB   = 16;
  localparam int STAT_LED_LSB = 0;
  localparam int STAT_OUT_LSB = 4;
  localparam int STAT_RUN_BIT = 8;
  localparam int STAT_BLK_LSB = 12;

  // Reset values
  localparam logic [VAL_W-1:0] RST_VAL   = 16'h0000;
  localparam logic [CNT_W-1:0] RST_CNT   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
  localparam logic [SEG_W-1:0] RST_SEGS  = 9'h000;
  localparam logic [31:0]      RST_WORD  = 32'h0000_0000;

  // Timer step: one second at a 10 ns clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_S      = 1000000000;
  localparam int SEC_STEP_S    = 1;
  localparam int SEC_CYCLES    = SEC_STEP_S * NS_PER_S / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    AF_OFF       = 4'h0,
    AF_IN_FAULT  = 4'h1,
    AF_PROG_EVT  = 4'h2,
    AF_HEAT_FLT  = 4'h3,
    AF_ABS_MIN   = 4'h4,
    AF_ABS_MAX   = 4'h5,
    AF_DEV_BAND  = 4'h6,
    AF_DEV_UNDER = 4'h7,
    AF_DEV_OVER  = 4'h8
  } pau_func_t;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_ON   = 2'b01,
    TS_OFF  = 2'b10
  } pau_tst_t;

  typedef struct packed {
    pau_func_t               func;
    logic signed [VAL_W-1:0] thresh;
    logic [CNT_W-1:0]        t1;
    logic [CNT_W-1:0]        t2;
    logic [SEG_W-1:0]        segs;
    logic                    block_en;
  } pau_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic              read;
  } pau_req_t;
endpackage : pau_pkg
`default_nettype wire

// [verif/pau_sensor_model.sv]
// Sensor front end model: periodic measurement updates
`default_nettype none
module pau_sensor_model #(
  parameter int PERIOD = 4
) (
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  input  wire logic signed [pau_pkg::VAL_W-1:0]  pv_set,
  output logic signed [pau_pkg::VAL_W-1:0]       pv_value,
  output logic                                   pv_update
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_ff;
  // Value only moves on an update, as a real converter result would
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff    <= 0;
      pv_update <= 1'b0;
      pv_value  <= 16'sh0000;
    end else begin
      cnt_ff    <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
      pv_update <= (cnt_ff == PERIOD - 1);
      if (cnt_ff == PERIOD - 1) begin
        pv_value <= pv_set;
      end
    end
  end
endmodule : pau_sensor_model
`default_nettype wire

// [verif/process_alarm_unit_tb_top.sv]
// Self-checking bench for the process alarm unit
`default_nettype none
module process_alarm_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 10; // Short second keeps timer runs brief
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0000_0000;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [31:0]        hwdata = 32'h0000_0000;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic signed [15:0] pv_set = 16'sh0000;
  logic signed [15:0] pv_value;
  logic               pv_update;
  logic               sensor_fault = 1'b0;
  logic               prog_running = 1'b0;
  logic [3:0]         prog_segment = 4'h0;
  logic               heater_fault_pin = 1'b0;
  logic               run_pin = 1'b1;
  logic [3:0]         alarm_out;
  logic [3:0]         alarm_led;
  logic [31:0]        rd;
  int                 failures = 0;
  int                 samples_checked = 0;
  int                 sp_m;
  int                 thr_m[4];
  logic [8:0]         seg_m[4];
  logic [3:0]         fn_m[4];

  always #5 hclk = ~hclk;

  pau_core #(.SEC_CYCLES(SEC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pv_value(pv_value),
    .pv_update(pv_update), .sensor_fault(sensor_fault), .prog_running(prog_running),
    .prog_segment(prog_segment), .heater_fault_pin(heater_fault_pin),
    .run_pin(run_pin), .alarm_out(alarm_out), .alarm_led(alarm_led));

  pau_sensor_model #(.PERIOD(4)) sensor (
    .hclk(hclk), .hresetn(hresetn), .pv_set(pv_set), .pv_value(pv_value),
    .pv_update(pv_update));

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask : wait_ready

  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic cfg(input logic [3:0] blk, input logic [31:0] tim0);
    bus(1'b1, pau_pkg::OFS_FUNC, {16'h0, fn_m[3], fn_m[2], fn_m[1], fn_m[0]});
    bus(1'b1, pau_pkg::OFS_BLOCK, {28'h0, blk});
    bus(1'b1, pau_pkg::OFS_SETPOINT, {16'h0, 16'(sp_m)});
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'(pau_pkg::OFS_THR_BASE + 4 * i), {16'h0, 16'(thr_m[i])});
      bus(1'b1, 8'(pau_pkg::OFS_TIM_BASE + 4 * i), (i == 0) ? tim0 : 32'h0);
      bus(1'b1, 8'(pau_pkg::OFS_SEG_BASE + 4 * i), {23'h0, seg_m[i]});
    end
  endtask : cfg

  // Expected recognition of every alarm from the present stimulus
  function automatic logic [3:0] exp_led();
    logic [3:0] e;
    int         pv;
    int         t;
    pv = pv_set;
    for (int i = 0; i < 4; i++) begin
      t = thr_m[i];
      case (fn_m[i])
        4'h1: e[i] = sensor_fault;
        4'h2: e[i] = prog_running && seg_m[i][4'(prog_segment - 4'h1)];
        4'h3: e[i] = heater_fault_pin;
        4'h4: e[i] = pv < t;
        4'h5: e[i] = sensor_fault || pv > t;
        4'h6: e[i] = sensor_fault || ((t >= 0) ? (pv < sp_m - t || pv > sp_m + t)
                                               : (pv >= sp_m + t && pv <= sp_m - t));
        4'h7: e[i] = pv < sp_m - t;
        4'h8: e[i] = sensor_fault || pv > sp_m + t;
        default: e[i] = 1'b0;
      endcase
    end
    return e;
  endfunction : exp_led

  // Covers update period, input sync and output latency
  task automatic settle;
    repeat (16) @(posedge hclk);
  endtask : settle

  task automatic t_regs;
    bus(1'b1, pau_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    bus(1'b0, pau_pkg::OFS_STATUS, 32'h0);
    check("status", rd, 32'h0000_F100);
    bus(1'b1, pau_pkg::OFS_SETPOINT, 32'h0000_8123);
    bus(1'b0, pau_pkg::OFS_SETPOINT, 32'h0);
    check("setpoint", rd, 32'h0000_8123);
    bus(1'b0, 8'hFC, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("Test registers done");
  endtask : t_regs

  // Every function code on all four alarms over one stimulus sweep
  task automatic t_funcs;
    int pvs[7] = '{-50, 12, 20, 31, 45, 100, 31};
    sp_m = 30;
    thr_m = '{-20, 5, 20, 60};
    for (int i = 0; i < 4; i++) begin
      seg_m[i] = 9'(1 << (2 * i));
    end
    for (int f = 0; f < 9; f++) begin
      fn_m = '{4{4'(f)}};
      cfg(4'h0, 32'h0);
      for (int k = 0; k < 7; k++) begin
        pv_set           <= 16'(pvs[k]);
        sensor_fault     <= (k == 6);
        heater_fault_pin <= k[0];
        prog_running     <= (k != 2);
        prog_segment     <= 4'(k + 1);
        settle();
        check("led", {28'h0, alarm_led}, {28'h0, exp_led()});
        check("out", {28'h0, alarm_out}, {28'h0, exp_led()});
      end
    end
    $display("Test functions done");
  endtask : t_funcs

  // On time and rising count for each timer mode, rows t1 t2 hi_min hi_max r_min r_max
  task automatic t_timers;
    int tab[4][6] = '{'{0, 0, 50, 58, 1, 1}, '{2, 0, 10, 21, 1, 1},
                      '{0, 2, 30, 48, 1, 1}, '{2, 2, 18, 46, 2, 3}};
    int   hi;
    int   rises;
    logic prev;
    fn_m = '{4'h5, 4'h0, 4'h0, 4'h0};
    thr_m = '{0, 0, 0, 0};
    sensor_fault <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      cfg(4'h0, {16'(tab[c][1]), 16'(tab[c][0])});
      pv_set <= -16'sd10;
      settle();
      pv_set <= 16'sd10;
      hi = 0;
      rises = 0;
      prev = alarm_out[0];
      repeat (60) begin
        @(posedge hclk);
        hi += int'(alarm_out[0]);
        rises += int'(alarm_out[0] & ~prev);
        prev = alarm_out[0];
      end
      check("on time", 32'(hi >= tab[c][2] && hi <= tab[c][3]), 32'h1);
      check("pulses", 32'(rises >= tab[c][4] && rises <= tab[c][5]), 32'h1);
      check("led held", {31'h0, alarm_led[0]}, 32'h1);
    end
    $display("Test timers done");
  endtask : t_timers

  task automatic t_block;
    fn_m = '{4'h4, 4'h1, 4'h0, 4'h0};
    cfg(4'h3, 32'h0);
    pv_set       <= -16'sd10;
    sensor_fault <= 1'b1;
    run_pin      <= 1'b0;
    settle();
    check("out run off", {28'h0, alarm_out}, 32'h0);
    check("led run off", {28'h0, alarm_led}, 32'h2);
    run_pin <= 1'b1;
    settle();
    check("out blocked", {28'h0, alarm_out}, 32'h2);
    pv_set <= 16'sd10;
    settle();
    pv_set <= -16'sd10;
    settle();
    check("out released", {28'h0, alarm_out}, 32'h3);
    $display("Test blocking done");
  endtask : t_block

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_funcs();
    t_timers();
    t_block();
    end_of_test();
  end
endmodule : process_alarm_unit_tb_top
`default_nettype wire
